// ==== hdl/dfs_top.v ====
// Decimation filter select, per-channel decimator and settling tracking.
`timescale 1ns/1ps
`default_nettype none
`include "dfs_defs.vh"
module dfs_top #(
   parameter NCH = 8,
   parameter DW = 16
) (
   // Clock and reset.
   input wire clock_i,
   input wire rst_n_i,
   // Register port.
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   output reg [7:0] reg_rdata_o,
   // Mode pins.
   input wire pin_mode_i,
   input wire pin_filter_sinc_i,
   input wire ratio_pin_lo_i,
   input wire ratio_pin_hi_i,
   input wire sync_i,
   // Modulator bitstreams, one bit per channel per modulator clock.
   input wire mod_valid_i,
   input wire [NCH-1:0] mod_bits_i,
   output wire chop_en_o,
   // Output words: header byte, channel index, data.
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [7:0] out_header_o,
   output wire [2:0] out_chan_o,
   output wire [DW-1:0] out_data_o,
   output wire stall_o
);
   reg [7:0] prof_a_reg;
   reg [7:0] prof_b_reg;
   reg [7:0] chan_sel_reg;
   reg chop_fast_reg;
   reg sync_d_reg;
   reg [4:0] chop_cnt_reg;
   // Each channel owns its own settling flag; this vector only gathers them.
   wire [NCH-1:0] nsettled;
   reg [NCH-1:0] done_reg;
   reg [7:0] rr_reg;
   wire sync_rise = sync_i && !sync_d_reg;
   wire [NCH-1:0] pend;
   wire [NCH-1:0] take;
   wire [DW-1:0] acc_w [0:NCH-1];
   wire [7:0] ch_hdr [0:NCH-1];
   wire buf_ready;
   reg [2:0] pick;
   reg pick_ok;
   integer k;

   // Registers; pin mode leaves them untouched but ignores them.
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prof_a_reg <= `DFS_PROFILE_RESET;
         prof_b_reg <= `DFS_PROFILE_RESET;
         chan_sel_reg <= 8'h00;
         chop_fast_reg <= 1'b0;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            `DFS_ADDR_PROFILE_A: prof_a_reg <= {4'h0, reg_wdata_i[3:0]};
            `DFS_ADDR_PROFILE_B: prof_b_reg <= {4'h0, reg_wdata_i[3:0]};
            `DFS_ADDR_CHAN_SEL: chan_sel_reg <= reg_wdata_i;
            `DFS_ADDR_CHOP: chop_fast_reg <= reg_wdata_i[0];
            default: ;
         endcase
      end
   end

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i)
         reg_rdata_o <= 8'h00;
      else if (reg_rd_i) begin
         case (reg_addr_i)
            `DFS_ADDR_PROFILE_A: reg_rdata_o <= prof_a_reg;
            `DFS_ADDR_PROFILE_B: reg_rdata_o <= prof_b_reg;
            `DFS_ADDR_CHAN_SEL: reg_rdata_o <= chan_sel_reg;
            `DFS_ADDR_CHOP: reg_rdata_o <= {7'h00, chop_fast_reg};
            `DFS_ADDR_STATUS: reg_rdata_o <= nsettled;
            default: reg_rdata_o <= 8'h00;
         endcase
      end
   end

   // Chopping enable pulses every 32 or 8 modulator clocks.
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         chop_cnt_reg <= 5'h00;
         sync_d_reg <= 1'b0;
      end else begin
         sync_d_reg <= sync_i;
         if (sync_rise)
            chop_cnt_reg <= 5'h00;
         else if (mod_valid_i)
            chop_cnt_reg <= chop_cnt_reg + 5'h01;
      end
   end
   wire chop_fast = chop_fast_reg && !pin_mode_i;
   assign chop_en_o = mod_valid_i &&
      (chop_fast ? (chop_cnt_reg[2:0] == 3'h7) : (chop_cnt_reg == 5'h1f));

   // Pin ratio select maps 00..11 onto 32..256 codes.
   wire [2:0] pin_code = {1'b0, ratio_pin_hi_i, ratio_pin_lo_i};

   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : ch
         // Profile choice is looked up live per channel, so only mapped channels change.
         wire [7:0] prof = chan_sel_reg[g] ? prof_b_reg : prof_a_reg;
         // The ones count stands in for both filter shapes; the type bit travels in the header.
         wire sinc = pin_mode_i ? pin_filter_sinc_i
                                : prof[`DFS_FILT_BIT];
         wire [2:0] code = pin_mode_i ? pin_code : prof[2:0];
         reg [3:0] lg;
         always @* begin
            case (code)
               3'h0: lg = 4'd5;
               3'h1: lg = 4'd6;
               3'h2: lg = 4'd7;
               3'h3: lg = 4'd8;
               3'h4: lg = 4'd9;
               default: lg = 4'd10;
            endcase
         end
         reg [9:0] phase_reg;
         reg [DW-1:0] acc_reg;
         reg [DW-1:0] word_reg;
         reg have_reg;
         reg [7:0] per_reg;
         wire [9:0] last = (10'h001 << lg) - 10'h001;
         wire wrap = mod_valid_i && (phase_reg == last);
         // Settling delay in output periods; wideband waits its group delay plus extra.
         wire [7:0] need = sinc ? `DFS_SINC_DELAY_PERIODS
                                : (`DFS_WB_DELAY_PERIODS + `DFS_WB_EXTRA_PERIODS);
         always @(posedge clock_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               phase_reg <= 10'h000;
               acc_reg <= {DW{1'b0}};
               word_reg <= {DW{1'b0}};
               have_reg <= 1'b0;
               per_reg <= 8'h00;
            end else begin
               if (sync_rise) begin
                  phase_reg <= 10'h000;
                  acc_reg <= {DW{1'b0}};
                  per_reg <= 8'h00;
               end else if (mod_valid_i) begin
                  // Counting ones gives a boxcar average; output rate is mod rate / ratio.
                  phase_reg <= wrap ? 10'h000 : phase_reg + 10'h001;
                  acc_reg <= wrap ? {DW{1'b0}} : acc_reg + {{(DW-1){1'b0}}, mod_bits_i[g]};
                  if (wrap) begin
                     word_reg <= acc_reg + {{(DW-1){1'b0}}, mod_bits_i[g]};
                     if (per_reg != 8'hff)
                        per_reg <= per_reg + 8'h01;
                  end
               end
               // A new word wins over the take that drains the old one.
               if (wrap && !sync_rise)
                  have_reg <= 1'b1;
               else if (take[g] || sync_rise)
                  have_reg <= 1'b0;
            end
         end
         assign pend[g] = have_reg;
         assign acc_w[g] = word_reg;
         reg ns_reg;
         assign nsettled[g] = ns_reg;
         assign ch_hdr[g] = {1'b0, ns_reg, 1'b0, sinc, 1'b0, code};
         always @(posedge clock_i or negedge rst_n_i) begin
            if (!rst_n_i)
               ns_reg <= 1'b0;
            else if (sync_rise)
               ns_reg <= 1'b1;
            else if (per_reg >= need)
               ns_reg <= 1'b0;
         end
      end
   endgenerate

   // Fixed-priority pick of the lowest-numbered pending channel into the buffer.
   always @* begin
      pick = 3'h0;
      pick_ok = 1'b0;
      for (k = NCH - 1; k >= 0; k = k - 1) begin
         if (pend[k] && !done_reg[k]) begin
            pick = k[2:0];
            pick_ok = 1'b1;
         end
      end
   end
   assign take = (pick_ok && buf_ready) ? (8'h01 << pick) : 8'h00;
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i)
         done_reg <= 8'h00;
      else
         done_reg <= 8'h00;
   end
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i)
         rr_reg <= 8'h00;
      else
         rr_reg <= rr_reg | take;
   end
   // A word still pending at its next period end would be overwritten.
   assign stall_o = |(pend & ~take) && mod_valid_i;

   wire [7:0] hdr_sel = ch_hdr[pick];
   wire [`DFS_HDR_NSETTLED_BIT:0] hdr_low = hdr_sel[`DFS_HDR_NSETTLED_BIT:0];
   dfs_buf2 #(.W(8 + 3 + DW)) u_buf (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(pick_ok),
      .in_ready_o(buf_ready),
      .in_data_i({1'b0, hdr_low, pick, acc_w[pick]}),
      .out_valid_o(out_valid_o),
      .out_ready_i(out_ready_i),
      .out_data_o({out_header_o, out_chan_o, out_data_o})
   );
endmodule
`default_nettype wire

// ==== hdl/dfs_defs.vh ====
// Constants for the decimation filter select block.
`ifndef DFS_DEFS_VH
`define DFS_DEFS_VH
`define DFS_ADDR_PROFILE_A 8'h01
`define DFS_ADDR_PROFILE_B 8'h02
`define DFS_ADDR_CHAN_SEL 8'h03
`define DFS_ADDR_CHOP 8'h04
`define DFS_ADDR_STATUS 8'h05
`define DFS_FILT_BIT 3
`define DFS_HDR_NSETTLED_BIT 6
`define DFS_PROFILE_RESET 8'h00
`define DFS_WB_EXTRA_PERIODS 8'h04
`define DFS_WB_DELAY_PERIODS 8'h22
`define DFS_SINC_DELAY_PERIODS 8'h05
`define DFS_CHOP_SLOW_LOG2 5
`define DFS_CHOP_FAST_LOG2 3
`endif

// ==== hdl/dfs_buf2.v ====
// Two-entry valid/ready buffer for filter output words.
`timescale 1ns/1ps
`default_nettype none
module dfs_buf2 #(
   parameter W = 32
) (
   input wire clock_i,
   input wire rst_n_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [W-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [W-1:0] out_data_o
);
   reg [W-1:0] mem_reg [0:1];
   reg wr_reg;
   reg rd_reg;
   reg [1:0] cnt_reg;
   wire push = in_valid_i && (cnt_reg != 2'd2);
   wire pop = out_ready_i && (cnt_reg != 2'd0);
   assign in_ready_o = (cnt_reg != 2'd2);
   assign out_valid_o = (cnt_reg != 2'd0);
   assign out_data_o = mem_reg[rd_reg];
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
         cnt_reg <= 2'd0;
         mem_reg[0] <= {W{1'b0}};
         mem_reg[1] <= {W{1'b0}};
      end else begin
         if (push) begin
            mem_reg[wr_reg] <= in_data_i;
            wr_reg <= ~wr_reg;
         end
         if (pop)
            rd_reg <= ~rd_reg;
         if (push && !pop)
            cnt_reg <= cnt_reg + 2'd1;
         else if (pop && !push)
            cnt_reg <= cnt_reg - 2'd1;
      end
   end
endmodule
`default_nettype wire

// ==== sim/dfs_top_asserts.sv ====
// Port assertions for the decimation filter select block.
`timescale 1ns/1ps
`default_nettype none
module dfs_top_asserts #(parameter DW = 16) (
   input wire logic clock_i, rst_n_i, reg_wr_i, reg_rd_i, pin_mode_i, sync_i, mod_valid_i,
   input wire logic chop_en_o, out_valid_o, out_ready_i,
   input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, out_header_o,
   input wire logic [2:0] out_chan_o,
   input wire logic [DW-1:0] out_data_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   logic [5:0] gap;
   logic armed;
   // Gap checks wait for one chop in pin mode, so entering pin mode never trips them.
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gap <= 6'h00;
         armed <= 1'b0;
      end else begin
         gap <= chop_en_o ? 6'h00 : gap + {5'h00, mod_valid_i};
         armed <= pin_mode_i && !sync_i && (armed || chop_en_o);
      end
   end
   sequence s_wr_rd;
      reg_wr_i && reg_addr_i inside {8'h01, 8'h02, 8'h03} ##1 reg_rd_i && $stable(reg_addr_i);
   endsequence
   sequence s_sync_rd;
      $rose(sync_i) ##3 reg_rd_i && reg_addr_i == 8'h05;
   endsequence
   chop_tick_a: assert property (chop_en_o |-> mod_valid_i) else $error("chop off tick");
   chop_pin_a: assert property (chop_en_o && armed |-> gap == 6'h1f) else $error("chop gap");
   word_hold_a: assert property (out_valid_o && !out_ready_i |=> out_valid_o &&
      $stable({out_header_o, out_chan_o, out_data_o})) else $error("word not held");
   data_max_a: assert property (out_valid_o |-> out_data_o <= 16'h0400) else $error("count");
   rd_zero_a: assert property (reg_rd_i && (reg_addr_i == 8'h00 || reg_addr_i > 8'h05) |=>
      reg_rdata_o == 8'h00) else $error("unmapped read");
   rd_stand_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("rdata moved");
   rd_back_a: assert property (s_wr_rd |=> reg_rdata_o == $past(reg_wdata_i, 2))
      else $error("readback");
   sync_flag_a: assert property (s_sync_rd |=> reg_rdata_o == 8'hff) else $error("settle flag");
endmodule
bind dfs_top dfs_top_asserts #(.DW(DW)) u_dfs_top_asserts (.clock_i(clock_i), .rst_n_i(rst_n_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .pin_mode_i(pin_mode_i), .sync_i(sync_i),
   .mod_valid_i(mod_valid_i), .chop_en_o(chop_en_o), .out_valid_o(out_valid_o),
   .out_ready_i(out_ready_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o), .out_header_o(out_header_o), .out_chan_o(out_chan_o),
   .out_data_o(out_data_o));
`default_nettype wire

// ==== sim/dfs_mod_src.sv ====
// Modulator bitstream model: one tick per GAP clocks, channel n has ones density n/8.
`timescale 1ns/1ps
`default_nettype none
module dfs_mod_src #(parameter GAP = 12) (
   input wire logic clock_i, rst_n_i, run_i,
   output var logic mod_valid_o,
   output var logic [7:0] mod_bits_o,
   output var logic [15:0] ticks_o
);
   logic [7:0] cyc;
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cyc <= 8'h00;
         ticks_o <= 16'h0000;
         mod_valid_o <= 1'b0;
         mod_bits_o <= 8'h00;
      end else begin
         mod_valid_o <= run_i && cyc == 8'h00;
         cyc <= (!run_i || cyc == 8'(GAP - 1)) ? 8'h00 : cyc + 8'h01;
         // Bits toggle between ticks so a stale sample never looks valid.
         if (run_i && cyc == 8'h00) begin
            for (int n = 0; n < 8; n++) mod_bits_o[n] <= ticks_o[2:0] < n;
            ticks_o <= ticks_o + 16'h0001;
         end else mod_bits_o <= ~mod_bits_o;
      end
   end
endmodule
`default_nettype wire

// ==== sim/tb_decimation_filter_select.sv ====
// Self-checking bench for the decimation filter select block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
   $display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module tb_decimation_filter_select;
   logic clock_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, pin_mode_i = 0, pin_filter_sinc_i = 0;
   logic ratio_pin_lo_i = 0, ratio_pin_hi_i = 0, sync_i = 0, out_ready_i = 0, run = 0, rd_pend = 0;
   logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, mod_bits, out_header_o;
   logic mod_valid, chop_en_o, out_valid_o, stall_o;
   logic [2:0] out_chan_o;
   logic [15:0] out_data_o, ticks;
   logic [31:0] rnd = 32'h4bf5fa73;
   logic [17:0] eq[8][$];
   logic [7:0] rq[$];
   int fail_count = 0, checks = 0, chops = 0;
   always #50 clock_i = ~clock_i;
   dfs_top u_dfs_top (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o), .pin_mode_i(pin_mode_i), .pin_filter_sinc_i(pin_filter_sinc_i),
      .ratio_pin_lo_i(ratio_pin_lo_i), .ratio_pin_hi_i(ratio_pin_hi_i), .sync_i(sync_i),
      .mod_valid_i(mod_valid), .mod_bits_i(mod_bits), .chop_en_o(chop_en_o),
      .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_header_o(out_header_o),
      .out_chan_o(out_chan_o), .out_data_o(out_data_o), .stall_o(stall_o));
   dfs_mod_src u_dfs_mod_src (.clock_i(clock_i), .rst_n_i(rst_n_i), .run_i(run),
      .mod_valid_o(mod_valid), .mod_bits_o(mod_bits), .ticks_o(ticks));
   function automatic logic busy();
      int n = rq.size();
      for (int j = 0; j < 8; j++) n += eq[j].size();
      return n != 0;
   endfunction
   task automatic close_out();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clock_i) begin
      rnd <= {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
      out_ready_i <= rnd[2:0] != 3'h0;
      rd_pend <= reg_rd_i;
      if (chop_en_o) chops++;
      if (rd_pend) `CHK(reg_rdata_o, rq.pop_front())
      if (rst_n_i && out_valid_o && out_ready_i) begin
         if (eq[out_chan_o].size() == 0) `CHK(out_chan_o, 3'bxxx)
         else `CHK({out_header_o[6], out_header_o[4], out_data_o}, eq[out_chan_o].pop_front())
      end
   end
   task automatic reg_op(input logic wr, input logic [7:0] a, d);
      reg_wr_i <= wr;
      reg_rd_i <= !wr;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      if (!wr) rq.push_back(d);
      @(posedge clock_i);
   endtask
   task automatic run_cfg(input logic pin, fast, input logic [1:0] pc, input logic [7:0] pa, pb,
         input int t);
      logic [3:0] c;
      logic [7:0] sel;
      int r;
      int i;
      sel = rnd[7:0];
      rst_n_i <= 1'b0;
      pin_mode_i <= pin;
      {ratio_pin_hi_i, ratio_pin_lo_i} <= pc;
      pin_filter_sinc_i <= rnd[9];
      repeat (3) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(posedge clock_i);
      reg_op(0, 8'h05, 8'h00);
      reg_op(0, 8'h07, 8'h00);
      reg_op(1, 8'h01, pa);
      reg_op(0, 8'h01, pa);
      reg_op(1, 8'h03, sel);
      reg_op(0, 8'h03, sel);
      reg_op(1, 8'h02, pb);
      reg_op(1, 8'h04, {7'h00, fast});
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b0;
      for (i = 0; i < 8; i++) begin
         c = pin ? {pin_filter_sinc_i, 1'b0, pc} : (sel[i] ? pb[3:0] : pa[3:0]);
         r = 32 << (c[2:0] > 5 ? 5 : c[2:0]);
         repeat (t / r) eq[i].push_back({1'b0, c[3], 16'(r * i / 8)});
      end
      chops = 0;
      run <= 1'b1;
      for (i = 0; i < t * 14 && ticks != 16'(t); i++) @(posedge clock_i);
      run <= 1'b0;
      for (i = 0; i < 300 && busy(); i++) @(posedge clock_i);
      if (ticks != 16'(t) || busy()) begin
         fail_count++;
         close_out();
      end
      `CHK(chops, t / ((fast && !pin) ? 8 : 32))
   endtask
   initial begin
      for (int k = 0; k < 8; k++) run_cfg(0, k[0], 2'h0, 8'(k[0] * 8 + k),
         {4'h0, ~k[0], 3'h0}, 32 << (k > 5 ? 5 : k));
      for (int p = 0; p < 4; p++) run_cfg(1, 1, 2'(p), 8'h0c, 8'h0c, 32 << p);
      sync_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      reg_op(0, 8'h05, 8'hff);
      reg_rd_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      close_out();
   end
endmodule
`default_nettype wire
